/* File: hdl/gp_pkg.sv */
// Shared constants, register map and carrier types of the eight-pin port block
package gp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned GP_PINS   = 8;
  localparam int unsigned GP_VECS   = 7;
  localparam int unsigned GP_MAP_W  = 3;
  localparam int unsigned GP_SENS_W = 2;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] GP_ADDR_LATCH = 8'h00;
  localparam logic [7:0] GP_ADDR_DIR   = 8'h04;
  localparam logic [7:0] GP_ADDR_OPT   = 8'h08;
  localparam logic [7:0] GP_ADDR_SENSE = 8'h0C;
  localparam logic [7:0] GP_ADDR_MAP   = 8'h10;
  localparam logic [7:0] GP_ADDR_CTRL  = 8'h14;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  GP_RST_PORT  = 8'h00;
  localparam logic [13:0] GP_RST_SENSE = 14'h0000;
  localparam logic [23:0] GP_RST_MAP   = 24'h000000;
  localparam logic        GP_RST_IMASK = 1'b1;
  localparam int unsigned GP_CTRL_IMASK_BIT = 0;
  localparam logic [2:0]  GP_MAP_NONE  = 3'h7;

  // Sensitivity codes
  localparam logic [1:0] GP_SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] GP_SENS_RISE     = 2'h1;
  localparam logic [1:0] GP_SENS_FALL     = 2'h2;
  localparam logic [1:0] GP_SENS_BOTH     = 2'h3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out_en;
    logic [7:0] out;
  } gp_af_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pullup_en;
  } gp_pad_t;

  typedef struct packed {
    logic [7:0]  latch;
    logic [7:0]  dir;
    logic [7:0]  opt;
    logic [13:0] sense;
    logic [23:0] map;
    logic        imask;
    logic [31:0] prdata;
    logic        pslverr;
  } gp_regs_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } gp_sync_t;

  typedef struct packed {
    logic prev;
    logic pending;
  } gp_edge_t;

endpackage : gp_pkg

/* File: hdl/gp_sync.sv */
// Two-stage synchroniser for the eight pin levels
`timescale 1ns/1ps
`default_nettype none
module gp_sync
  import gp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Levels
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  gp_sync_t st;
  gp_sync_t next_st;

  // Only the second stage reads the first one
  always_comb
  begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.s2;

endmodule : gp_sync
`default_nettype wire

/* File: hdl/gp_edge.sv */
// Request latch with edge or level sensitivity for one external interrupt vector
`timescale 1ns/1ps
`default_nettype none
module gp_edge
  import gp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Source and control
  input  wire logic       level,
  input  wire logic [1:0] sense,
  input  wire logic       fetch,
  input  wire logic       clear,
  // Request
  output logic            pending
);

  gp_edge_t st;
  gp_edge_t next_st;
  logic     rise;
  logic     fall;
  logic     set;

  always_comb
  begin
    rise = !st.prev && level;
    fall = st.prev && !level;
    case (sense)
      GP_SENS_FALL_LOW: set = fall || !level;
      GP_SENS_RISE:     set = rise;
      GP_SENS_FALL:     set = fall;
      GP_SENS_BOTH:     set = rise || fall;
      default:          set = 1'b0;
    endcase
    next_st.prev = level;
    // A new event wins over a clear in the same cycle
    next_st.pending = set || (st.pending && !fetch && !clear);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{prev: 1'b1, pending: 1'b0};
    else
      st <= next_st;
  end

  assign pending = st.pending;

  a_fetch_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (fetch && !set) |=> !pending) else $error("request survived vector fetch");

  a_sense_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (clear && !set) |=> !pending) else $error("request survived sensitivity change");

  a_fall_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (sense == GP_SENS_FALL && st.prev && !level) |=> pending ##0 $past(level) == 1'b0)
    else $error("falling edge not latched");

  a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
    (sense == GP_SENS_RISE && !st.pending && !(!st.prev && level)) |=> !pending)
    else $error("request without rising edge");

endmodule : gp_edge
`default_nettype wire

/* File: hdl/gp_port.sv */
// Eight-pin port with direction, option and data latches, pin drive and external interrupts
`timescale 1ns/1ps
`default_nettype none
module gp_port
  import gp_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Pins
  input  wire logic [7:0]  pin_in,
  output gp_pkg::gp_pad_t  pad,
  // Peripheral alternate functions
  input  wire gp_pkg::gp_af_t af,
  output logic      [7:0]  af_in,
  // CPU interrupt side
  input  wire logic [6:0]  vec_fetch,
  output logic      [6:0]  irq_req,
  output logic             wake
);

  // ----------------------------------------------------------------
  // State and nets
  // ----------------------------------------------------------------
  gp_regs_t    st;
  gp_regs_t    next_st;
  logic [7:0]  pin_sync;
  logic [7:0]  irq_pin_en;
  logic [7:0]  drive_val;
  logic [7:0]  read_val;
  logic [6:0]  vec_src;
  logic [6:0]  sense_clr;
  logic [6:0]  pending;
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        addr_ok;
  logic        wr_sense;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  gp_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------
  // Per-pin drive, read and peripheral input
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < GP_PINS; gi++)
    begin : g_pin
      // A peripheral output takes priority over the port programming
      assign drive_val[gi] = af.out_en[gi] ? af.out[gi] : st.latch[gi];
      // Low enable means driven; open-drain releases the pin on a one
      assign pad.oe_n[gi] = !(af.out_en[gi] ||
                              (st.dir[gi] && (st.opt[gi] || !st.latch[gi])));
      assign pad.out[gi] = drive_val[gi];
      assign pad.pullup_en[gi] = !st.dir[gi] && st.opt[gi] && !af.out_en[gi];
      assign irq_pin_en[gi] = !st.dir[gi] && st.opt[gi] && !af.out_en[gi];
      assign read_val[gi] = af.out_en[gi] ? af.out[gi] :
                            (st.dir[gi] ? st.latch[gi] : pin_sync[gi]);
      assign af_in[gi] = st.dir[gi] ? st.latch[gi] : pin_sync[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // External interrupt vectors
  // ----------------------------------------------------------------
  genvar gv;
  generate
    for (gv = 0; gv < GP_VECS; gv++)
    begin : g_vec
      // Shared pins are ANDed; a vector with no enabled pin idles high
      always_comb
      begin
        vec_src[gv] = 1'b1;
        for (int p = 0; p < GP_PINS; p++)
        begin
          if (irq_pin_en[p] && st.map[p*GP_MAP_W +: GP_MAP_W] == 3'(gv))
            vec_src[gv] = vec_src[gv] & pin_sync[p];
        end
      end

      assign sense_clr[gv] = wr_sense &&
        (pwdata[gv*GP_SENS_W +: GP_SENS_W] != st.sense[gv*GP_SENS_W +: GP_SENS_W]);

      gp_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (vec_src[gv]),
        .sense   (st.sense[gv*GP_SENS_W +: GP_SENS_W]),
        .fetch   (vec_fetch[gv]),
        .clear   (sense_clr[gv]),
        .pending (pending[gv])
      );
    end
  endgenerate

  // The CPU mask gates every request; any unmasked request wakes the device
  assign irq_req = st.imask ? 7'h00 : pending;
  assign wake    = |irq_req;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so pready can stay high
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign pready   = 1'b1;
  assign wr_en    = access && pwrite && addr_ok;
  assign wr_sense = wr_en && paddr == GP_ADDR_SENSE && pstrb[0] && pstrb[1];
  assign prdata   = st.prdata;
  assign pslverr  = st.pslverr;

  always_comb
  begin
    case (paddr)
      GP_ADDR_LATCH,
      GP_ADDR_DIR,
      GP_ADDR_OPT,
      GP_ADDR_SENSE,
      GP_ADDR_MAP,
      GP_ADDR_CTRL: addr_ok = 1'b1;
      default:      addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (setup)
    begin
      next_st.pslverr = !addr_ok;
      case (paddr)
        GP_ADDR_LATCH: next_st.prdata = {24'h000000, read_val};
        GP_ADDR_DIR:   next_st.prdata = {24'h000000, st.dir};
        GP_ADDR_OPT:   next_st.prdata = {24'h000000, st.opt};
        GP_ADDR_SENSE: next_st.prdata = {18'h00000, st.sense};
        GP_ADDR_MAP:   next_st.prdata = {8'h00, st.map};
        GP_ADDR_CTRL:  next_st.prdata = {31'h00000000, st.imask};
        default:       next_st.prdata = 32'h00000000;
      endcase
    end
    if (wr_en)
    begin
      case (paddr)
        GP_ADDR_LATCH:
        begin
          // Stored whatever the direction, ready for a switch to output
          if (pstrb[0])
            next_st.latch = pwdata[7:0];
        end
        GP_ADDR_DIR:
        begin
          if (pstrb[0])
            next_st.dir = pwdata[7:0];
        end
        GP_ADDR_OPT:
        begin
          if (pstrb[0])
            next_st.opt = pwdata[7:0];
        end
        GP_ADDR_SENSE:
        begin
          // Both low lanes are needed, so a code never splits across writes
          if (pstrb[0] && pstrb[1])
            next_st.sense = pwdata[13:0];
        end
        GP_ADDR_MAP:
        begin
          if (pstrb[0])
            next_st.map[7:0] = pwdata[7:0];
          if (pstrb[1])
            next_st.map[15:8] = pwdata[15:8];
          if (pstrb[2])
            next_st.map[23:16] = pwdata[23:16];
        end
        GP_ADDR_CTRL:
        begin
          if (pstrb[0])
            next_st.imask = pwdata[GP_CTRL_IMASK_BIT];
        end
        default:
        begin
          next_st.pslverr = st.pslverr;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.latch   <= GP_RST_PORT;
      st.dir     <= GP_RST_PORT;
      st.opt     <= GP_RST_PORT;
      st.sense   <= GP_RST_SENSE;
      st.map     <= GP_RST_MAP;
      st.imask   <= GP_RST_IMASK;
      st.prdata  <= 32'h00000000;
      st.pslverr <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_push_pull_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (st.dir[0] && st.opt[0] && !af.out_en[0]) |-> (!pad.oe_n[0] && pad.out[0] == st.latch[0]))
    else $error("push-pull pin not driven from latch");

  a_open_drain_float: assert property (@(posedge pclk) disable iff (!presetn)
    (st.dir[1] && !st.opt[1] && !af.out_en[1]) |-> (pad.oe_n[1] == st.latch[1]))
    else $error("open-drain pin drive wrong");

  a_af_override: assert property (@(posedge pclk) disable iff (!presetn)
    af.out_en[2] |-> (!pad.oe_n[2] && pad.out[2] == af.out[2]))
    else $error("peripheral output not on pin");

  a_read_af_out: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == GP_ADDR_LATCH && !st.dir[3] && af.out_en[3])
      |=> prdata[3] == $past(af.out[3]))
    else $error("read missed peripheral output");

  a_read_pin_in: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == GP_ADDR_LATCH && !st.dir[4] && !af.out_en[4])
      |=> prdata[4] == $past(pin_sync[4]))
    else $error("input read not pin level");

  a_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == GP_ADDR_LATCH && pstrb[0])
      |=> st.latch == $past(pwdata[7:0]))
    else $error("latch write lost");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    st.imask |-> irq_req == 7'h00)
    else $error("request passed CPU mask");

  a_af_in_latch: assert property (@(posedge pclk) disable iff (!presetn)
    st.dir[5] |-> af_in[5] == st.latch[5])
    else $error("peripheral input not latch");

  a_wake_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (!st.imask && |pending) |-> wake)
    else $error("no wake on unmasked request");

  a_reset_regs: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (st.dir == 8'h00 && st.opt == 8'h00))
    else $error("port registers not cleared");

  a_pslverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !addr_ok) |=> pslverr)
    else $error("unmapped access without error");

  a_pslverr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && addr_ok) |=> !pslverr)
    else $error("mapped access flagged as error");

  a_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && !addr_ok) |=> $stable(st))
    else $error("unmapped write changed state");

  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == GP_ADDR_DIR && pstrb[0]) |=> st.dir == $past(pwdata[7:0]))
    else $error("direction write lost");

  a_opt_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == GP_ADDR_OPT && pstrb[0]) |=> st.opt == $past(pwdata[7:0]))
    else $error("option write lost");

  a_sense_lanes: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == GP_ADDR_SENSE && !(pstrb[0] && pstrb[1])) |=> $stable(st.sense))
    else $error("sensitivity split across lanes");

  a_map_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == GP_ADDR_MAP && pstrb == 4'hF) |=> st.map == $past(pwdata[23:0]))
    else $error("pin map write lost");

  a_shared_and: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_pin_en[0] && irq_pin_en[1] && st.map[5:0] == 6'h00 && !pin_sync[1]) |-> !vec_src[0])
    else $error("low shared pin did not mask vector");

  a_af_in_pin: assert property (@(posedge pclk) disable iff (!presetn)
    !st.dir[6] |-> af_in[6] == pin_sync[6])
    else $error("peripheral input not pin level");

  a_read_latch_out: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && paddr == GP_ADDR_LATCH && st.dir[5] && !af.out_en[5]) |=> prdata[5] == $past(st.latch[5]))
    else $error("output read not latch");

  a_pullup_off: assert property (@(posedge pclk) disable iff (!presetn)
    (st.dir[7] || !st.opt[7]) |-> !pad.pullup_en[7])
    else $error("pull-up on outside pull-up input");

endmodule : gp_port
`default_nettype wire

/* File: hdl/gp_unused_guard.sv */
// Reserved empty file slot intentionally unused
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: bench/gp_pins_model.sv */
// Model of the circuitry outside the pins: drivers, pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module gp_pins_model
  import gp_pkg::*;
(
  // Clock
  input  wire logic            pclk,
  // Device side
  input  wire gp_pkg::gp_pad_t pad,
  // External drivers
  input  wire logic [7:0]      ext_en,
  input  wire logic [7:0]      ext_val,
  // Resolved levels
  output logic      [7:0]      pin_lvl
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // A line that nobody drives toggles, so a stale level never reads as valid
  logic [7:0] float_q = 8'h00;

  always @(posedge pclk)
    float_q <= ~pin_lvl;

  // The device driver wins over the outside one, then the pull-up
  always_comb
    for (int i = 0; i < 8; i++)
      pin_lvl[i] = !pad.oe_n[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : pad.pullup_en[i] ? 1'b1 : float_q[i];
endmodule : gp_pins_model
`default_nettype wire

/* File: bench/test_gpio_port_with_ext_interrupts.sv */
// Self-checking bench for the eight-pin port with external interrupts
`timescale 1ns/1ps
`default_nettype none
module test_gpio_port_with_ext_interrupts;
  import gp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [7:0]  pin_lvl;
  gp_pad_t     pad;
  gp_af_t      af;
  logic [7:0]  af_in;
  logic [6:0]  vec_fetch;
  logic [6:0]  irq_req;
  logic        wake;
  logic [7:0]  ext_en;
  logic [7:0]  ext_val;
  int          err_count;
  int          checks_done;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  lat;
  logic [7:0]  opt;
  logic [7:0]  dir;
  logic [1:0]  c;
  int          v;

  gp_port i_gp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in(pin_lvl), .pad(pad), .af(af), .af_in(af_in), .vec_fetch(vec_fetch), .irq_req(irq_req),
    .wake(wake));

  gp_pins_model i_gp_pins_model (.pclk(pclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_lvl));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] z32(input logic [7:0] a);
    return {24'h000000, a};
  endfunction : z32

  task wrap_up;
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Called just after a rising edge; one idle cycle follows every transfer
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      err_count++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp, what);
  endtask : rd_chk

  task fetch(input logic [6:0] m);
    vec_fetch <= m;
    @(posedge pclk);
    vec_fetch <= 7'h00;
  endtask : fetch

  // Expected request bits per sensitivity code, indexed by the code
  task exp_irq(input logic [3:0] e, input string what);
    check(z32({1'b0, irq_req}), 32'(e[c]) << v, what);
    check(z32({7'h00, wake}), 32'(e[c]), "wake");
  endtask : exp_irq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, af, vec_fetch, ext_val} = '0;
    pstrb = 4'hF;
    ext_en = 8'hFF;
    presetn = 1'b0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(32'h3eefae18));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
    rd_chk(GP_ADDR_LATCH, 32'h00000000, "data at reset");
    rd_chk(GP_ADDR_DIR, 32'h00000000, "dir at reset");
    rd_chk(GP_ADDR_OPT, 32'h00000000, "opt at reset");
    apb(1'b0, 8'h18, 32'h00000000);
    check(32'(er), 32'h00000001, "unmapped error");
    repeat (4)
    begin
      lat = 8'($urandom);
      opt = 8'($urandom);
      ext_en <= 8'h00;
      apb(1'b1, GP_ADDR_LATCH, z32(lat));
      apb(1'b1, GP_ADDR_OPT, z32(opt));
      apb(1'b1, GP_ADDR_DIR, 32'h000000FF);
      check(z32(pad.oe_n), z32(~(opt | ~lat)), "drive enable");
      check(z32(pin_lvl | pad.oe_n), z32(lat), "pin level");
      rd_chk(GP_ADDR_LATCH, z32(lat), "latch read");
      check(z32(af_in), z32(lat), "af input from latch");
    end
    lat = 8'($urandom);
    opt = 8'($urandom);
    ext_val <= 8'($urandom);
    ext_en <= 8'hFF;
    apb(1'b1, GP_ADDR_DIR, 32'h00000000);
    apb(1'b1, GP_ADDR_LATCH, z32(lat));
    apb(1'b1, GP_ADDR_OPT, z32(opt));
    tick(3);
    rd_chk(GP_ADDR_LATCH, z32(ext_val), "input read");
    check(z32(af_in), z32(ext_val), "af input from pin");
    check(z32(pad.pullup_en), z32(opt), "pull-up");
    apb(1'b1, GP_ADDR_OPT, 32'h000000FF);
    apb(1'b1, GP_ADDR_DIR, 32'h000000FF);
    check(z32(pad.out), z32(lat), "latch after turn");
    apb(1'b1, GP_ADDR_OPT, 32'h00000000);
    apb(1'b1, GP_ADDR_DIR, 32'h00000000);
    repeat (4)
    begin
      opt = 8'($urandom);
      lat = 8'($urandom);
      dir = 8'($urandom);
      af <= {opt, lat};
      ext_en <= ~opt;
      ext_val <= dir;
      tick(3);
      rd_chk(GP_ADDR_LATCH, z32((lat & opt) | (dir & ~opt)), "read with af");
      check(z32(pad.oe_n), z32(~opt), "af drive");
      check(z32(pad.out & opt), z32(lat & opt), "af value");
    end
    af <= '0;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    apb(1'b1, GP_ADDR_OPT, 32'h00000003);
    for (int k = 0; k < 4; k++)
    begin
      c = 2'(k);
      v = 2 * k;
      apb(1'b1, GP_ADDR_MAP, 32'h00FFFFC0 | (v << 3) | v);
      apb(1'b1, GP_ADDR_SENSE, 32'(c) << (2 * v));
      apb(1'b1, GP_ADDR_CTRL, 32'h00000001);
      tick(4);
      fetch(7'h7F);
      ext_val <= 8'hFE;
      tick(4);
      check(z32({1'b0, irq_req}), 32'h00000000, "masked");
      apb(1'b1, GP_ADDR_CTRL, 32'h00000000);
      exp_irq(4'b1101, "fall");
      fetch(7'(1 << v));
      tick(2);
      exp_irq(4'b0001, "level after fetch");
      ext_val <= 8'hFF;
      tick(4);
      exp_irq(4'b1011, "rise");
      fetch(7'(1 << v));
      tick(2);
      exp_irq(4'b0000, "fetch clears");
      ext_val <= 8'hFD;
      tick(4);
      fetch(7'(1 << v));
      tick(2);
      ext_val <= 8'hFC;
      tick(4);
      ext_val <= 8'hFD;
      tick(4);
      exp_irq(4'b0001, "shared low");
      ext_val <= 8'hFF;
      tick(4);
      exp_irq(4'b1011, "shared release");
      apb(1'b1, GP_ADDR_SENSE, 32'(c ^ 2'h1) << (2 * v));
      tick(1);
      exp_irq(4'b0000, "sense change");
    end
    // A sensitivity write on one lane only must be ignored
    pstrb <= 4'h1;
    apb(1'b1, GP_ADDR_SENSE, 32'h00003FFF);
    pstrb <= 4'hF;
    rd_chk(GP_ADDR_SENSE, 32'h00002000, "sense lanes");
    wrap_up();
  end
endmodule : test_gpio_port_with_ext_interrupts
`default_nettype wire
